// file: pkg/sense_monitor_defs.vh
// Purpose: Constants for the current-sense monitor digital block
// Assumes: 200 MHz core clock
// Notes: Register pointers, field positions, reset values, delay counts
`ifndef SENSE_MONITOR_DEFS_VH
`define SENSE_MONITOR_DEFS_VH

`define CLK_MHZ 200
`define PTR_SENSE_HI 8'h00
`define PTR_SENSE_LO 8'h01
`define PTR_CM_HI 8'h02
`define PTR_CM_LO 8'h03
`define PTR_OUT_HI 8'h04
`define PTR_OUT_LO 8'h05
`define PTR_REF_HI 8'h06
`define PTR_REF_LO 8'h07
`define PTR_TEMP_HI 8'h08
`define PTR_TEMP_LO 8'h09
`define PTR_CTRL1 8'h0a
`define PTR_CTRL2 8'h0b
`define CTRL1_RESET 8'h00
`define CTRL2_RESET 8'h00
`define TEMP_RESET 12'h800
`define RESULT_RESET 12'h000
`define CTRL1_MODE_MSB 7
`define CTRL1_MODE_LSB 5
`define CTRL1_LATCH_CLR 4
`define CTRL1_PWRDN 3
`define CTRL1_CHAN_MSB 2
`define CTRL1_CHAN_LSB 0
`define CTRL2_QUAL_SEL 3
`define CTRL2_RETRY_SEL 2
`define CTRL2_WMASK 8'h0c
`define MODE_DIRECT 3'h0
`define MODE_OPAMP 3'h3
`define MODE_COMP 3'h7
`define CHAN_CYCLE 3'h7
`define ADDR_BASE 7'h70
// Delays in microseconds, cycles derived from the clock rate
`define QUAL_LONG_US 1000
`define QUAL_SHORT_US 100
`define RETRY_LONG_US 50000
`define RETRY_SHORT_US 10000
`define CYCLE_STEP_US 2000
`define QUAL_LONG_CYC (`QUAL_LONG_US * `CLK_MHZ)
`define QUAL_SHORT_CYC (`QUAL_SHORT_US * `CLK_MHZ)
`define RETRY_LONG_CYC (`RETRY_LONG_US * `CLK_MHZ)
`define RETRY_SHORT_CYC (`RETRY_SHORT_US * `CLK_MHZ)
`define CYCLE_STEP_CYC (`CYCLE_STEP_US * `CLK_MHZ)

`endif

// file: src/fault_qualifier.v
// Purpose: Qualify, latch and retry the amplifier fault output
// Assumes: over_ref_i already synchronised to clk_i
// Notes: Delay counts are parameters so a bench can shorten them
`timescale 1ns/10ps
`default_nettype none
`include "sense_monitor_defs.vh"

module fault_qualifier #(
   parameter [31:0] QUAL_LONG = `QUAL_LONG_CYC,
   parameter [31:0] QUAL_SHORT = `QUAL_SHORT_CYC,
   parameter [31:0] RETRY_LONG = `RETRY_LONG_CYC,
   parameter [31:0] RETRY_SHORT = `RETRY_SHORT_CYC
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // Control
   input wire [2:0] mode_i,
   input wire qual_short_i,
   input wire retry_short_i,
   input wire clear_i,
   input wire over_ref_i,
   // Result
   output reg fault_o
);

   localparam [2:0] ST_WATCH = 3'b001;
   localparam [2:0] ST_LATCH = 3'b010;
   localparam [2:0] ST_DIRECT = 3'b100;

   reg [2:0] state_q;
   reg [31:0] count_q;
   wire qualified_mode;
   wire [31:0] qual_limit;
   wire [31:0] retry_limit;

   assign qualified_mode = (mode_i == `MODE_COMP) || (mode_i == `MODE_OPAMP);
   assign qual_limit = qual_short_i ? QUAL_SHORT : QUAL_LONG;
   assign retry_limit = retry_short_i ? RETRY_SHORT : RETRY_LONG;

   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_q <= ST_DIRECT;
         count_q <= 32'h0;
         fault_o <= 1'b0;
      end
      else if (!qualified_mode)
      begin
         // Unqualified codes pass the comparison straight through
         state_q <= ST_DIRECT;
         count_q <= 32'h0;
         fault_o <= over_ref_i;
      end
      else
      begin
         case (state_q)
            ST_DIRECT:
            begin
               state_q <= ST_WATCH;
               count_q <= 32'h0;
               fault_o <= 1'b0;
            end
            ST_WATCH:
            begin
               fault_o <= 1'b0;
               if (!over_ref_i)
               begin
                  count_q <= 32'h0;
               end
               else if (count_q + 32'h1 >= qual_limit)
               begin
                  state_q <= ST_LATCH;
                  count_q <= 32'h0;
                  fault_o <= 1'b1;
               end
               else
               begin
                  count_q <= count_q + 32'h1;
               end
            end
            ST_LATCH:
            begin
               if (clear_i || (count_q + 32'h1 >= retry_limit))
               begin
                  // Software clear or retry expiry restarts the watch
                  state_q <= ST_WATCH;
                  count_q <= 32'h0;
                  fault_o <= 1'b0;
               end
               else
               begin
                  count_q <= count_q + 32'h1;
               end
            end
            default:
            begin
               state_q <= ST_WATCH;
               count_q <= 32'h0;
               fault_o <= 1'b0;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// file: src/sense_monitor.v
// Purpose: I2C target with result and control registers plus fault qualifier
// Assumes: SCL, SDA, address levels and comparator arrive asynchronously
// Notes: Conversion results are supplied by the converter as 12-bit words, die temperature as 9 bits
`timescale 1ns/10ps
`default_nettype none
`include "sense_monitor_defs.vh"

// Functional notes
// - Die temperature is 9-bit two's complement, half-degree steps, left aligned.
// - Qualification delay is 1 ms after reset, 100 us when selected.
// - Retry delay is 50 ms after reset, 10 ms when selected.
// - Behaviour code 000 passes the comparison through unqualified.
// - Code 111 asserts after continuous over-reference for the delay, then latches.
// - Retry expiry clears the latch and restarts qualification.
// - Code 011 uses the same qualify, latch and retry sequence.
// - A control bit lets software clear a latched fault.
// - Bit 7 of the first control byte picks op-amp or comparator behaviour.
// - Target only, up to 400 kHz; the controller makes clock and START.
// - Idle target answers only its own pin-selected address among sixteen.
// - Address LSB zero means write, one means read.
// - Address match is acknowledged by pulling data low one clock.
// - Controller NAKs the last read byte; target then releases data.
// - Pointers 0x00-0x09 are read-only results, 0x0a-0x0b read/write control.
// - Results split: upper 8 bits, then lower 4 in top nibble, zero below.
// - Control one: behaviour 7:5, latch clear 4, power down 3, channel 2:0.
// - Channel codes select sources; code 111 steps through channels 0-6 every 2 ms, then repeats 2-6.
// - Latch clear releases the latch and then returns to zero itself.
// - Control two: bit 3 qualify delay, bit 2 retry delay, others zero.
// - Power down bit is zero at reset, one requests shutdown.
module sense_monitor #(
   parameter [31:0] QUAL_LONG = `QUAL_LONG_CYC,
   parameter [31:0] QUAL_SHORT = `QUAL_SHORT_CYC,
   parameter [31:0] RETRY_LONG = `RETRY_LONG_CYC,
   parameter [31:0] RETRY_SHORT = `RETRY_SHORT_CYC,
   parameter [31:0] CYCLE_STEP = `CYCLE_STEP_CYC
) (
   // Clock and reset
   input wire CORE_CLK_I,
   input wire RST_N_I,
   // Serial bus, open drain data
   input wire SCL_I,
   input wire SDA_I,
   output reg SDA_O,
   output reg SDA_OE_O,
   // Address level pins, each decoded to four levels
   input wire [1:0] ADDR_LEVEL_PIN_HI_I,
   input wire [1:0] ADDR_LEVEL_PIN_LO_I,
   // Converter results
   input wire [11:0] SENSE_RESULT_I,
   input wire [11:0] CM_RESULT_I,
   input wire [11:0] OUT_RESULT_I,
   input wire [11:0] REF_RESULT_I,
   input wire [8:0] TEMP_RESULT_I,
   input wire RESULT_VALID_I,
   // Analog comparator status
   input wire OVER_REF_I,
   // Analog controls
   output reg [2:0] CHANNEL_SEL_O,
   output reg POWER_DOWN_O,
   output reg OPAMP_SEL_O,
   output reg FAULT_O
);

   localparam [5:0] ST_IDLE = 6'b000001;
   localparam [5:0] ST_ADDR = 6'b000010;
   localparam [5:0] ST_ACK = 6'b000100;
   localparam [5:0] ST_RX = 6'b001000;
   localparam [5:0] ST_TX = 6'b010000;
   localparam [5:0] ST_MACK = 6'b100000;

   // Two-flop synchronisers, then one history stage for edges
   reg [1:0] scl_s_q;
   reg [1:0] sda_s_q;
   reg [1:0] ovr_s_q;
   reg scl_h_q;
   reg sda_h_q;
   reg [3:0] alvl_s1_q;
   reg [3:0] alvl_s2_q;

   reg [5:0] state_q;
   reg [7:0] shift_q;
   reg [3:0] bit_q;
   reg rw_q;
   reg ptr_phase_q;
   reg [7:0] ptr_q;
   reg [7:0] ctrl1_q;
   reg [7:0] ctrl2_q;
   reg clear_q;
   reg [11:0] res_q [0:4];
   reg [2:0] cyc_chan_q;
   reg [31:0] cyc_cnt_q;

   wire scl_rise;
   wire scl_fall;
   wire start_cond;
   wire stop_cond;
   wire [6:0] own_addr;
   wire fault_w;
   reg [7:0] rd_byte;
   integer i;

   assign scl_rise = scl_s_q[1] && !scl_h_q;
   assign scl_fall = !scl_s_q[1] && scl_h_q;
   assign start_cond = scl_s_q[1] && scl_h_q && sda_h_q && !sda_s_q[1];
   assign stop_cond = scl_s_q[1] && scl_h_q && !sda_h_q && sda_s_q[1];
   // First pin steps by eight, second by two in the byte address
   assign own_addr = `ADDR_BASE + {3'h0, alvl_s2_q[3:2], 2'h0} + {5'h0, alvl_s2_q[1:0]};

   always @(posedge CORE_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         scl_s_q <= 2'h3;
         sda_s_q <= 2'h3;
         ovr_s_q <= 2'h0;
         scl_h_q <= 1'b1;
         sda_h_q <= 1'b1;
         alvl_s1_q <= 4'h0;
         alvl_s2_q <= 4'h0;
      end
      else
      begin
         scl_s_q <= {scl_s_q[0], SCL_I};
         sda_s_q <= {sda_s_q[0], SDA_I};
         ovr_s_q <= {ovr_s_q[0], OVER_REF_I};
         scl_h_q <= scl_s_q[1];
         sda_h_q <= sda_s_q[1];
         alvl_s1_q <= {ADDR_LEVEL_PIN_HI_I, ADDR_LEVEL_PIN_LO_I};
         alvl_s2_q <= alvl_s1_q;
      end
   end

   // Read mux: results left aligned, low nibble zero
   always @*
   begin
      rd_byte = 8'h00;
      case (ptr_q)
         `PTR_SENSE_HI: rd_byte = res_q[0][11:4];
         `PTR_SENSE_LO: rd_byte = {res_q[0][3:0], 4'h0};
         `PTR_CM_HI: rd_byte = res_q[1][11:4];
         `PTR_CM_LO: rd_byte = {res_q[1][3:0], 4'h0};
         `PTR_OUT_HI: rd_byte = res_q[2][11:4];
         `PTR_OUT_LO: rd_byte = {res_q[2][3:0], 4'h0};
         `PTR_REF_HI: rd_byte = res_q[3][11:4];
         `PTR_REF_LO: rd_byte = {res_q[3][3:0], 4'h0};
         `PTR_TEMP_HI: rd_byte = res_q[4][11:4];
         `PTR_TEMP_LO: rd_byte = {res_q[4][3:0], 4'h0};
         `PTR_CTRL1: rd_byte = ctrl1_q;
         `PTR_CTRL2: rd_byte = ctrl2_q;
         default: rd_byte = 8'h00;
      endcase
   end

   // Result capture from the converter, all results on each valid strobe
   always @(posedge CORE_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         for (i = 0; i < 4; i = i + 1)
            res_q[i] <= `RESULT_RESET;
         res_q[4] <= `TEMP_RESET;
      end
      else if (RESULT_VALID_I)
      begin
         res_q[0] <= SENSE_RESULT_I;
         res_q[1] <= CM_RESULT_I;
         res_q[2] <= OUT_RESULT_I;
         res_q[3] <= REF_RESULT_I;
         res_q[4] <= {TEMP_RESULT_I, 3'h0};
      end
   end

   // Channel cycling: step one source every 2 ms on code 111
   always @(posedge CORE_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         cyc_chan_q <= 3'h0;
         cyc_cnt_q <= 32'h0;
      end
      else if (ctrl1_q[`CTRL1_CHAN_MSB:`CTRL1_CHAN_LSB] != `CHAN_CYCLE)
      begin
         cyc_chan_q <= 3'h0;
         cyc_cnt_q <= 32'h0;
      end
      else if (cyc_cnt_q + 32'h1 >= CYCLE_STEP)
      begin
         cyc_cnt_q <= 32'h0;
         // Sense gain entries collapse to one slot: uses last gain
         cyc_chan_q <= (cyc_chan_q >= 3'h6) ? 3'h2 : cyc_chan_q + 3'h1;
      end
      else
      begin
         cyc_cnt_q <= cyc_cnt_q + 32'h1;
      end
   end

   // Serial target state machine
   always @(posedge CORE_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         state_q <= ST_IDLE;
         shift_q <= 8'h00;
         bit_q <= 4'h0;
         rw_q <= 1'b0;
         ptr_phase_q <= 1'b0;
         ptr_q <= 8'h00;
         ctrl1_q <= `CTRL1_RESET;
         ctrl2_q <= `CTRL2_RESET;
         clear_q <= 1'b0;
         SDA_O <= 1'b0;
         SDA_OE_O <= 1'b0;
      end
      else
      begin
         // Latch clear acts one cycle then self-clears
         clear_q <= 1'b0;
         if (ctrl1_q[`CTRL1_LATCH_CLR])
         begin
            ctrl1_q[`CTRL1_LATCH_CLR] <= 1'b0;
            clear_q <= 1'b1;
         end
         if (start_cond)
         begin
            // Repeated START keeps the pointer for the read phase
            state_q <= ST_ADDR;
            bit_q <= 4'h0;
            SDA_OE_O <= 1'b0;
         end
         else if (stop_cond)
         begin
            state_q <= ST_IDLE;
            SDA_OE_O <= 1'b0;
         end
         else
         begin
            case (state_q)
               ST_IDLE:
               begin
                  SDA_OE_O <= 1'b0;
               end
               ST_ADDR:
               begin
                  if (scl_rise)
                  begin
                     shift_q <= {shift_q[6:0], sda_s_q[1]};
                     bit_q <= bit_q + 4'h1;
                  end
                  else if (scl_fall && bit_q == 4'h8)
                  begin
                     if (shift_q[7:1] == own_addr)
                     begin
                        rw_q <= shift_q[0];
                        ptr_phase_q <= !shift_q[0];
                        SDA_OE_O <= 1'b1;
                        state_q <= ST_ACK;
                     end
                     else
                     begin
                        state_q <= ST_IDLE;
                     end
                  end
               end
               ST_ACK:
               begin
                  // Ack bit ends on its falling edge
                  if (scl_fall)
                  begin
                     bit_q <= 4'h0;
                     if (rw_q)
                     begin
                        shift_q <= {rd_byte[6:0], 1'b0};
                        SDA_OE_O <= !rd_byte[7];
                        ptr_q <= ptr_q + 8'h1;
                        state_q <= ST_TX;
                     end
                     else
                     begin
                        SDA_OE_O <= 1'b0;
                        state_q <= ST_RX;
                     end
                  end
               end
               ST_RX:
               begin
                  if (scl_rise)
                  begin
                     shift_q <= {shift_q[6:0], sda_s_q[1]};
                     bit_q <= bit_q + 4'h1;
                  end
                  else if (scl_fall && bit_q == 4'h8)
                  begin
                     SDA_OE_O <= 1'b1;
                     state_q <= ST_ACK;
                     if (ptr_phase_q)
                     begin
                        ptr_q <= shift_q;
                        ptr_phase_q <= 1'b0;
                     end
                     else
                     begin
                        if (ptr_q == `PTR_CTRL1)
                           ctrl1_q <= shift_q;
                        else if (ptr_q == `PTR_CTRL2)
                           ctrl2_q <= shift_q & `CTRL2_WMASK;
                        ptr_q <= ptr_q + 8'h1;
                     end
                  end
               end
               ST_TX:
               begin
                  if (scl_fall)
                  begin
                     if (bit_q == 4'h7)
                     begin
                        SDA_OE_O <= 1'b0;
                        state_q <= ST_MACK;
                     end
                     else
                     begin
                        SDA_OE_O <= !shift_q[7];
                        shift_q <= {shift_q[6:0], 1'b0};
                        bit_q <= bit_q + 4'h1;
                     end
                  end
               end
               ST_MACK:
               begin
                  if (scl_rise)
                  begin
                     // Controller NAK: release and wait for STOP
                     if (sda_s_q[1])
                        state_q <= ST_IDLE;
                     else
                        state_q <= ST_ACK;
                  end
               end
               default:
               begin
                  state_q <= ST_IDLE;
                  SDA_OE_O <= 1'b0;
               end
            endcase
         end
      end
   end

   fault_qualifier #(
      .QUAL_LONG(QUAL_LONG),
      .QUAL_SHORT(QUAL_SHORT),
      .RETRY_LONG(RETRY_LONG),
      .RETRY_SHORT(RETRY_SHORT)
   ) u_qual (
      .clk_i(CORE_CLK_I),
      .rst_n_i(RST_N_I),
      .mode_i(ctrl1_q[`CTRL1_MODE_MSB:`CTRL1_MODE_LSB]),
      .qual_short_i(ctrl2_q[`CTRL2_QUAL_SEL]),
      .retry_short_i(ctrl2_q[`CTRL2_RETRY_SEL]),
      .clear_i(clear_q),
      .over_ref_i(ovr_s_q[1]),
      .fault_o(fault_w)
   );

   // Registered analog controls
   always @(posedge CORE_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
      begin
         CHANNEL_SEL_O <= 3'h0;
         POWER_DOWN_O <= 1'b0;
         OPAMP_SEL_O <= 1'b1;
         FAULT_O <= 1'b0;
      end
      else
      begin
         CHANNEL_SEL_O <= (ctrl1_q[2:0] == `CHAN_CYCLE) ? cyc_chan_q : ctrl1_q[2:0];
         POWER_DOWN_O <= ctrl1_q[`CTRL1_PWRDN];
         OPAMP_SEL_O <= !ctrl1_q[`CTRL1_MODE_MSB];
         FAULT_O <= fault_w;
      end
   end

endmodule

`default_nettype wire

// file: sim/sense_monitor_monitor.sv
// Purpose: Port checker for the sense monitor
// Assumes: Slow serial clock, open-drain data line
// Notes: Bound to every sense_monitor instance
`timescale 1ns/10ps
`default_nettype none
module sense_monitor_monitor (
   // Clock and reset
   input wire logic CORE_CLK_I,
   input wire logic RST_N_I,
   // Bus and status pins
   input wire logic SCL_I,
   input wire logic SDA_I,
   input wire logic SDA_O,
   input wire logic SDA_OE_O,
   input wire logic OVER_REF_I,
   input wire logic POWER_DOWN_O,
   input wire logic OPAMP_SEL_O,
   input wire logic FAULT_O
);
   // Cycles since the comparator input was last high, saturating
   logic [3:0] quiet_q;
   always @(posedge CORE_CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         quiet_q <= 4'hf;
      else if (OVER_REF_I)
         quiet_q <= 4'h0;
      else if (quiet_q != 4'hf)
         quiet_q <= quiet_q + 4'h1;
   end
   default clocking @(posedge CORE_CLK_I);
   endclocking
   default disable iff (!RST_N_I);
   reset_idle_a: assert property (
      $rose(RST_N_I) |-> !SDA_OE_O && !FAULT_O && OPAMP_SEL_O)
      else $error("outputs not idle after reset");
   sda_low_only_a: assert property (SDA_OE_O |-> !SDA_O)
      else $error("data driven high");
   oe_scl_high_a: assert property (SCL_I && $past(SCL_I) |-> $stable(SDA_OE_O))
      else $error("data drive moved while clock high");
   oe_move_low_a: assert property ($changed(SDA_OE_O) |-> !SCL_I)
      else $error("data drive moved outside clock low");
   start_quiet_a: assert property (
      SCL_I && $past(SCL_I) && $fell(SDA_I) |-> !SDA_OE_O [*8])
      else $error("target drove data right after start");
   stop_quiet_a: assert property (
      SCL_I && $past(SCL_I) && $rose(SDA_I) |=> !SDA_OE_O [*8])
      else $error("target drove data after stop");
   ctrl_on_low_a: assert property (
      $changed(POWER_DOWN_O) || $changed(OPAMP_SEL_O) |-> !SCL_I)
      else $error("control output moved outside a write");
   fault_cause_a: assert property ($rose(FAULT_O) |-> quiet_q < 4'h8)
      else $error("fault raised without input");
   ack_seen_c: cover property ($rose(SDA_OE_O));
   fault_set_c: cover property ($rose(FAULT_O));
   fault_clr_c: cover property ($fell(FAULT_O) && OVER_REF_I);
endmodule
bind sense_monitor sense_monitor_monitor u_mon (
   .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I), .SCL_I(SCL_I), .SDA_I(SDA_I),
   .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .OVER_REF_I(OVER_REF_I),
   .POWER_DOWN_O(POWER_DOWN_O), .OPAMP_SEL_O(OPAMP_SEL_O), .FAULT_O(FAULT_O));
`default_nettype wire

// file: sim/i2c_ctl_model.sv
// Purpose: Behavioural bus controller facing the sense monitor
// Assumes: Bench resolves the pulled-up data line
// Notes: 125 ns serial clock, idle high between frames
`timescale 1ns/10ps
`default_nettype none
module i2c_ctl_model (
   // Serial pins
   output logic scl_o,
   output logic pull_o,
   input wire logic sda_i
);
   localparam real Q = 31.25;
   initial
   begin
      scl_o = 1'b1;
      pull_o = 1'b0;
   end
   // Serves as START and repeated START
   task start;
      pull_o = 1'b0;
      #Q scl_o = 1'b1;
      #Q pull_o = 1'b1;
      #Q scl_o = 1'b0;
      #Q;
   endtask
   task stop;
      pull_o = 1'b1;
      #Q scl_o = 1'b1;
      #Q pull_o = 1'b0;
      #(2 * Q);
   endtask
   // Byte plus acknowledge slot; all ones releases the line for reads
   task xfer(input logic [7:0] w, input logic a, output logic [7:0] r,
      output logic k);
      logic [8:0] s;
      logic [8:0] q;
      integer i;
      s = {w, a};
      for (i = 8; i >= 0; i = i - 1)
      begin
         pull_o = !s[i];
         #Q scl_o = 1'b1;
         #Q q[i] = sda_i;
         #Q scl_o = 1'b0;
         #Q;
      end
      r = q[8:1];
      k = q[0];
   endtask
endmodule
`default_nettype wire

// file: sim/sense_monitor_tb.sv
// Purpose: Self-checking bench for the sense monitor
// Assumes: Shortened delay parameters
// Notes: One task per scenario, all waits bounded
`timescale 1ns/10ps
`default_nettype none
module sense_monitor_tb;
   localparam [31:0] QL = 32'd20;
   localparam [31:0] QS = 32'd5;
   localparam [31:0] RL = 32'd2000;
   localparam [31:0] RS = 32'd400;
   logic clk, rst_n, scl, pull, sda_o, sda_oe, valid, over, pd, opamp, fault;
   wire logic sda;
   logic [1:0] pin_hi, pin_lo;
   logic [11:0] sense, cm, outv, refv;
   logic [8:0] temp;
   logic [2:0] chan;
   logic [7:0] dev;
   logic [7:0] dat [16];
   int n_fail, samples_checked;
   // Pull-up: released line reads high
   assign sda = !(pull || (sda_oe && !sda_o));
   sense_monitor #(.QUAL_LONG(QL), .QUAL_SHORT(QS), .RETRY_LONG(RL), .RETRY_SHORT(RS),
      .CYCLE_STEP(32'd50)) DUT (
      .CORE_CLK_I(clk), .RST_N_I(rst_n), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
      .SDA_OE_O(sda_oe), .ADDR_LEVEL_PIN_HI_I(pin_hi), .ADDR_LEVEL_PIN_LO_I(pin_lo),
      .SENSE_RESULT_I(sense), .CM_RESULT_I(cm), .OUT_RESULT_I(outv),
      .REF_RESULT_I(refv), .TEMP_RESULT_I(temp), .RESULT_VALID_I(valid),
      .OVER_REF_I(over), .CHANNEL_SEL_O(chan), .POWER_DOWN_O(pd),
      .OPAMP_SEL_O(opamp), .FAULT_O(fault));
   i2c_ctl_model ctl (.scl_o(scl), .pull_o(pull), .sda_i(sda));
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = !clk;
   end
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task print_verdict;
      $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Leaves inputs free to change just after an edge
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task send(input logic [7:0] b);
      logic [7:0] r;
      logic k;
      ctl.xfer(b, 1'b1, r, k);
      chk(k, 1'b0);
   endtask
   task wr(input logic [7:0] ptr, input int n);
      ctl.start();
      send(dev);
      send(ptr);
      for (int i = 0; i < n; i++)
         send(dat[i]);
      ctl.stop();
   endtask
   task rd(input logic [7:0] ptr, input int n);
      logic k;
      ctl.start();
      send(dev);
      send(ptr);
      ctl.start();
      send(dev | 8'h01);
      for (int i = 0; i < n; i++)
         ctl.xfer(8'hff, i == n - 1, dat[i], k);
      ctl.stop();
   endtask
   // A wait that runs past its bound ends the run
   task wait_f(input logic lvl, input int lo, input int hi);
      int n;
      n = 0;
      while (fault !== lvl && n <= hi)
      begin
         tick(1);
         n++;
      end
      chk(n >= lo && n <= hi, 1'b1);
      if (n > hi)
         print_verdict();
   endtask
   task t_reset;
      rd(8'h00, 13);
      for (int i = 0; i < 13; i++)
         chk(dat[i], (i == 8) ? 8'h80 : 8'h00);
      chk({pd, opamp, fault, chan}, 6'h10);
      $display("test reset_values done");
   endtask
   task t_ctrl;
      dat[0] = 8'h0b;
      dat[1] = 8'hff;
      wr(8'h0a, 2);
      dat[0] = 8'h55;
      wr(8'h00, 1);
      tick(4);
      chk({pd, chan}, 4'hb);
      rd(8'h0a, 2);
      chk(dat[0], 8'h0b);
      chk(dat[1], 8'h0c);
      rd(8'h00, 1);
      chk(dat[0], 8'h00);
      $display("test control_regs done");
   endtask
   task t_cycle;
      logic [2:0] c;
      int n;
      dat[0] = 8'h07;
      wr(8'h0a, 1);
      // First loop finds a step, second times the next one
      for (int j = 0; j < 2; j++)
      begin
         c = chan;
         n = 0;
         while (chan === c && n < 60)
         begin
            tick(1);
            n++;
         end
      end
      chk(n[15:0], 16'd50);
      chk(chan, c + 3'h1);
      $display("test channel_cycle done");
   endtask
   task t_result;
      tick(1);
      sense = 12'habc;
      cm = 12'h123;
      outv = 12'h456;
      refv = 12'h789;
      temp = 9'h1f3;
      valid = 1'b1;
      tick(1);
      valid = 1'b0;
      rd(8'h00, 10);
      chk({dat[0], dat[1]}, {sense, 4'h0});
      chk({dat[2], dat[3]}, {cm, 4'h0});
      chk({dat[4], dat[5]}, {outv, 4'h0});
      chk({dat[6], dat[7]}, {refv, 4'h0});
      chk({dat[8], dat[9]}, {temp, 7'h00});
      $display("test results done");
   endtask
   task t_addr;
      logic [7:0] r;
      logic k;
      for (int i = 0; i < 16; i++)
      begin
         tick(1);
         {pin_hi, pin_lo} = i[3:0];
         tick(8);
         dev = 8'he0 + {3'h0, i[3:0], 1'b0};
         ctl.start();
         ctl.xfer(dev, 1'b1, r, k);
         chk(k, 1'b0);
         ctl.stop();
         ctl.start();
         ctl.xfer(dev ^ 8'h02, 1'b1, r, k);
         chk(k, 1'b1);
         ctl.stop();
      end
      $display("test addresses done");
   endtask
   task t_fault;
      tick(1);
      over = 1'b1;
      wait_f(1'b1, 1, 5);
      over = 1'b0;
      wait_f(1'b0, 1, 5);
      // Earlier tests left the short delays selected
      dat[0] = 8'he0;
      dat[1] = 8'h00;
      wr(8'h0a, 2);
      tick(1);
      chk(opamp, 1'b0);
      // Short bursts must never qualify
      for (int i = 0; i < 4; i++)
      begin
         over = 1'b1;
         tick(QL - 6);
         over = 1'b0;
         tick(2);
      end
      chk(fault, 1'b0);
      over = 1'b1;
      wait_f(1'b1, QL, QL + 6);
      over = 1'b0;
      tick(QL);
      chk(fault, 1'b1);
      dat[0] = 8'hf0;
      wr(8'h0a, 1);
      tick(4);
      chk(fault, 1'b0);
      rd(8'h0a, 1);
      chk(dat[0], 8'he0);
      dat[0] = 8'h60;
      dat[1] = 8'h0c;
      wr(8'h0a, 2);
      tick(1);
      chk(opamp, 1'b1);
      over = 1'b1;
      wait_f(1'b1, QS, QS + 6);
      wait_f(1'b0, RS - 1, RS + 4);
      wait_f(1'b1, QS, QS + 6);
      over = 1'b0;
      $display("test fault_control done");
   endtask
   initial
   begin
      rst_n = 1'b0;
      pin_hi = 2'h1;
      pin_lo = 2'h2;
      sense = 12'h000;
      cm = 12'h000;
      outv = 12'h000;
      refv = 12'h000;
      temp = 9'h000;
      valid = 1'b0;
      over = 1'b0;
      n_fail = 0;
      samples_checked = 0;
      dev = 8'hec;
      tick(2);
      rst_n = 1'b1;
      tick(6);
      t_reset();
      t_ctrl();
      t_cycle();
      t_result();
      t_addr();
      t_fault();
      print_verdict();
   end
endmodule
`default_nettype wire
